// file: dpot_pkg.sv
package dpot_pkg;
  // ==========================================================
  // Identification byte
  localparam logic [4:0] DPOT_ID_PREFIX    = 5'h16;  // Arbitrary value, replace per product
  localparam int         DPOT_ID_SEL_BIT   = 2;
  localparam int         DPOT_ID_RW_BIT    = 0;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] DPOT_ADDR_WIPER   = 8'h00;
  localparam logic [7:0] DPOT_ADDR_MODE    = 8'h01;
  localparam logic [7:0] DPOT_ADDR_ACCESS  = 8'h02;
  // ==========================================================
  // Fields and reset values
  localparam int         DPOT_ACR_VOL_BIT  = 7;
  localparam int         DPOT_ACR_SHDN_BIT = 6;
  localparam int         DPOT_ACR_BUSY_BIT = 5;
  localparam int         DPOT_MSR_MODE_BIT = 7;
  localparam int         DPOT_MSR_PREC_BIT = 6;
  localparam logic [6:0] DPOT_WIPER_RST    = 7'h40;
  localparam logic [6:0] DPOT_INIT_RST     = 7'h40;
  localparam logic [7:0] DPOT_ACR_RST      = 8'h40;
  localparam logic [7:0] DPOT_MSR_RST      = 8'h00;
  localparam logic [7:0] DPOT_ACR_WMASK    = 8'hc0;
  localparam logic [7:0] DPOT_MSR_WMASK    = 8'hc0;
  // ==========================================================
  // Timing
  localparam int         DPOT_CLK_MHZ      = 100;
  localparam int         DPOT_NVW_MS       = 20;
  localparam int         DPOT_NVW_CYC      = DPOT_NVW_MS * 1000 * DPOT_CLK_MHZ;
  localparam int         DPOT_PWRUP_CYC    = 16;
  localparam int         DPOT_HALF_CYC     = 63;
  localparam int         DPOT_BITS         = 8;
endpackage : dpot_pkg

// file: dpot_if.sv
`timescale 1ns/1ps
interface dpot_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_mst_o;
  logic sda_mst_oe_n;
  logic scl;
  logic sda;
  // Open drain wires with pull-ups
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = ((!sda_dev_oe_n && !sda_dev_o) || (!sda_mst_oe_n && !sda_mst_o)) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
  modport master (input scl, input sda, output scl_o, output scl_oe_n, output sda_mst_o, output sda_mst_oe_n);
endinterface : dpot_if

// file: dpot_slave.sv
`timescale 1ns/1ps
// Functional notes
// - Bytes travel most significant bit first
// - Device is slave, master drives clock
// - Data changes only while clock low
// - Data driver released after power up
// - Ignore bus until start condition seen
// - Starts during power up are ignored
// - Stop returns device to standby
// - Receiver pulls data low on ninth clock
// - Ack identification, address, write data bytes
// - Master acks read bytes it wants
// - Identification prefix and select bit must match
// - Write is id, address, data, stop
// - Nonvolatile write starts at stop, 20ms
// - Read is write id, address, restart, read id
// - Keep sending while master acknowledges
// - Master ends read with nack, stop
// - Host checks busy flag before reading store
// - Mode bit chooses rheostat or divider
// - Wiper code spans zero to 127
// - Addresses 0 wiper, 1 mode, 2 access
// - Volatile select steers address 0 access
// - Busy flag read only, blocks wiper and access writes
// - Wiper resets to 40h then reloads
module dpot_slave
  import dpot_pkg::*;
#(
  parameter int NVW_CYC = DPOT_NVW_CYC
) (
  input  wire logic       CLOCK,        // System clock
  input  wire logic       RESETN,       // Synchronous reset, low active
  dpot_if.device          BUS,          // Serial link
  input  wire logic       ADDR_SELECT_PIN, // Address select strap
  output logic [6:0]      WIPER,        // Wiper tap code
  output logic            DIVIDER_MODE, // 1 divider, 0 rheostat
  output logic            PRECISION_OFF,// Matching disabled
  output logic            SHUTDOWN_N,   // 0 puts pot in shutdown
  output logic            NV_WRITE_BUSY // Nonvolatile write running
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ID = 6'b000010, S_ADDR = 6'b000100,
    S_WDATA = 6'b001000, S_RDATA = 6'b010000, S_IGNORE = 6'b100000
  } dpot_state_type;

  // ==========================================================
  // Synchronisers and conditions
  logic [1:0] scl_sy_r, sda_sy_r;
  logic       scl_q_r, sda_q_r, sel_sy1_r, sel_r;
  always_ff @(posedge CLOCK) begin
    scl_sy_r  <= {scl_sy_r[0], BUS.scl};
    sda_sy_r  <= {sda_sy_r[0], BUS.sda};
    sel_sy1_r <= ADDR_SELECT_PIN;
    sel_r     <= sel_sy1_r;
    scl_q_r   <= scl_sy_r[1];
    sda_q_r   <= sda_sy_r[1];
  end
  wire scl_rise = scl_sy_r[1] && !scl_q_r;
  wire scl_fall = !scl_sy_r[1] && scl_q_r;
  // A data edge while the clock is high is only start or stop
  wire start_c  = scl_sy_r[1] && scl_q_r && sda_q_r && !sda_sy_r[1];
  wire stop_c   = scl_sy_r[1] && scl_q_r && !sda_q_r && sda_sy_r[1];

  // ==========================================================
  // Power up, reload of wiper
  logic [4:0] pwr_cnt_r;
  wire        pwr_done = (pwr_cnt_r == 5'(DPOT_PWRUP_CYC));
  always_ff @(posedge CLOCK) begin
    if (!RESETN) pwr_cnt_r <= '0;
    else if (!pwr_done) pwr_cnt_r <= pwr_cnt_r + 5'h01;
  end

  // ==========================================================
  // Byte engine
  dpot_state_type state_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, addr_r, tx_r;
  logic       ack_ph_r, drive_r, got_data_r;
  logic [7:0] rdata;
  wire  [7:0] acr_q;
  logic [6:0] init_r;
  logic [7:0] msr_r;
  logic       vol_r, shdn_r, busy_r;
  logic [31:0] nvw_cnt_r;
  assign acr_q = {vol_r, shdn_r, busy_r, 5'h00};
  always_comb begin
    case (addr_r)
      DPOT_ADDR_WIPER:  rdata = vol_r ? {1'b0, WIPER} : {1'b0, init_r};
      DPOT_ADDR_MODE:   rdata = msr_r;
      DPOT_ADDR_ACCESS: rdata = acr_q;
      default:          rdata = 8'h00;
    endcase
  end
  wire id_ok = (sh_r[7:3] == DPOT_ID_PREFIX) && (sh_r[DPOT_ID_SEL_BIT] == sel_r);

  logic wr_fire_r;
  always_ff @(posedge CLOCK) begin
    wr_fire_r <= 1'b0;
    if (!RESETN) begin
      state_r    <= S_IDLE;
      bit_r      <= '0;
      sh_r       <= '0;
      addr_r     <= '0;
      tx_r       <= '0;
      ack_ph_r   <= 1'b0;
      drive_r    <= 1'b0;
      got_data_r <= 1'b0;
    end else if (start_c && pwr_done) begin
      state_r  <= S_ID;
      bit_r    <= '0;
      ack_ph_r <= 1'b0;
      drive_r  <= 1'b0;
    end else if (stop_c) begin
      state_r    <= S_IDLE;
      drive_r    <= 1'b0;
      ack_ph_r   <= 1'b0;
      wr_fire_r  <= got_data_r;
      got_data_r <= 1'b0;
    end else if (state_r != S_IDLE && state_r != S_IGNORE) begin
      if (scl_rise && !ack_ph_r && state_r != S_RDATA) begin
        sh_r  <= {sh_r[6:0], sda_sy_r[1]};
        bit_r <= bit_r + 4'h1;
      end else if (scl_rise && ack_ph_r && state_r == S_RDATA) begin
        if (sda_sy_r[1]) state_r <= S_IGNORE;
      end else if (scl_rise && !ack_ph_r) begin
        bit_r <= bit_r + 4'h1;
      end else if (scl_fall) begin
        if (ack_ph_r) begin
          ack_ph_r <= 1'b0;
          bit_r    <= '0;
          drive_r  <= 1'b0;
          // Reload per byte: no auto-increment, reads repeat one register
          if (state_r == S_RDATA) begin
            tx_r    <= rdata;
            drive_r <= !rdata[7];
          end
        end else if (bit_r == 4'(DPOT_BITS)) begin
          ack_ph_r <= 1'b1;
          case (state_r)
            S_ID: begin
              if (!id_ok) state_r <= S_IGNORE;
              else begin
                drive_r <= 1'b1;
                state_r <= sh_r[DPOT_ID_RW_BIT] ? S_RDATA : S_ADDR;
                tx_r    <= rdata;
              end
            end
            S_ADDR: begin
              addr_r  <= sh_r;
              drive_r <= 1'b1;
              state_r <= S_WDATA;
            end
            S_WDATA: begin
              drive_r    <= 1'b1;
              got_data_r <= 1'b1;
            end
            S_RDATA: drive_r <= 1'b0;
            default: state_r <= S_IGNORE;
          endcase
        end else if (state_r == S_RDATA) begin
          drive_r <= !tx_r[7 - bit_r[2:0]];
        end
      end
    end
  end
  // First read byte bit 7 goes out on the fall that ends the id ack
  always_comb begin
    BUS.sda_dev_o    = 1'b0;
    BUS.sda_dev_oe_n = !drive_r;
  end

  // ==========================================================
  // Register writes
  wire wbyte = scl_fall && !ack_ph_r && bit_r == 4'(DPOT_BITS) && state_r == S_WDATA && !start_c && !stop_c;
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      WIPER  <= DPOT_WIPER_RST;
      init_r <= DPOT_INIT_RST;
      msr_r  <= DPOT_MSR_RST;
      vol_r  <= DPOT_ACR_RST[DPOT_ACR_VOL_BIT];
      shdn_r <= DPOT_ACR_RST[DPOT_ACR_SHDN_BIT];
    end else begin
      if (pwr_cnt_r == 5'(DPOT_PWRUP_CYC - 1)) WIPER <= init_r;
      if (wbyte) begin
        case (addr_r)
          DPOT_ADDR_WIPER: if (!busy_r) begin
            WIPER <= sh_r[6:0];
            if (!vol_r) init_r <= sh_r[6:0];
          end
          DPOT_ADDR_MODE: msr_r <= sh_r & DPOT_MSR_WMASK;
          DPOT_ADDR_ACCESS: if (!busy_r) begin
            vol_r  <= sh_r[DPOT_ACR_VOL_BIT];
            shdn_r <= sh_r[DPOT_ACR_SHDN_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Nonvolatile write timer
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      busy_r    <= 1'b0;
      nvw_cnt_r <= '0;
    end else if (wr_fire_r && (addr_r == DPOT_ADDR_MODE || (addr_r == DPOT_ADDR_WIPER && !vol_r))) begin
      busy_r    <= 1'b1;
      nvw_cnt_r <= 32'(NVW_CYC);
    end else if (busy_r) begin
      if (nvw_cnt_r <= 32'h1) busy_r <= 1'b0;
      nvw_cnt_r <= nvw_cnt_r - 32'h1;
    end
  end
  assign DIVIDER_MODE  = msr_r[DPOT_MSR_MODE_BIT];
  assign PRECISION_OFF = msr_r[DPOT_MSR_PREC_BIT];
  assign SHUTDOWN_N    = shdn_r;
  assign NV_WRITE_BUSY = busy_r;
endmodule : dpot_slave

// file: dpot_master.sv
`timescale 1ns/1ps
module dpot_master
  import dpot_pkg::*;
(
  input  wire logic       CLOCK,     // System clock
  input  wire logic       RESETN,    // Synchronous reset, low active
  dpot_if.master          BUS,       // Serial link
  input  wire logic       REQ,       // Start a transfer, pulse
  input  wire logic       RNW,       // 1 read, 0 write
  input  wire logic       SEL,       // Address select bit of target
  input  wire logic [7:0] ADDR,      // Register address
  input  wire logic [7:0] WDATA,     // Write data
  input  wire logic [3:0] RCOUNT,    // Bytes to read, at least 1
  output logic            BUSY,      // Transfer running
  output logic            DONE,      // One cycle at end
  output logic            NACK,      // Device failed to ack, valid with DONE
  output logic [7:0]      RDATA,     // Last byte read
  output logic            RVALID     // One cycle per byte read
);
  typedef enum logic [6:0] {
    M_IDLE = 7'b0000001, M_START = 7'b0000010, M_BIT = 7'b0000100, M_ACK = 7'b0001000,
    M_STOP = 7'b0010000, M_RSTART = 7'b0100000, M_DONE = 7'b1000000
  } dpot_mstate_type;
  // ==========================================================
  // Clock divider phases
  dpot_mstate_type st_r;
  logic [6:0] div_r;
  logic [1:0] ph_r;
  logic [7:0] sh_r, rsh_r;
  logic [2:0] bit_r;
  logic [2:0] byte_r;
  logic [3:0] left_r;
  logic       scl_r, sda_r, rx_r, nack_r, rnw_r;
  logic [1:0] sda_sy_r;
  wire tick = (div_r == 7'(DPOT_HALF_CYC / 2));
  always_ff @(posedge CLOCK) begin
    sda_sy_r <= {sda_sy_r[0], BUS.sda};
    if (!RESETN || st_r == M_IDLE || tick) div_r <= '0;
    else div_r <= div_r + 7'h01;
  end
  // Quarter-period phases: 0 low set data, 1 rise, 2 high sample, 3 fall
  always_ff @(posedge CLOCK) begin
    DONE <= 1'b0; RVALID <= 1'b0;
    if (!RESETN) begin
      st_r <= M_IDLE; ph_r <= '0; sh_r <= '0; rsh_r <= '0; bit_r <= '0; byte_r <= '0;
      left_r <= '0; scl_r <= 1'b1; sda_r <= 1'b1; rx_r <= 1'b0; nack_r <= 1'b0;
      rnw_r <= 1'b0; NACK <= 1'b0; RDATA <= '0;
    end else if (st_r == M_IDLE) begin
      if (REQ) begin
        st_r <= M_START; ph_r <= '0; byte_r <= '0; nack_r <= 1'b0; rnw_r <= RNW;
        left_r <= RCOUNT; sh_r <= {DPOT_ID_PREFIX, SEL, 1'b0, 1'b0};
      end
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      case (st_r)
        M_START, M_RSTART: begin
          case (ph_r)
            2'd0: begin sda_r <= 1'b1; scl_r <= 1'b1; end
            2'd1: sda_r <= 1'b0;
            2'd2: scl_r <= 1'b0;
            default: begin st_r <= M_BIT; bit_r <= '0; rx_r <= (byte_r >= 3'd3); end
          endcase
        end
        M_BIT: begin
          case (ph_r)
            2'd0: sda_r <= rx_r ? 1'b1 : sh_r[7 - bit_r];  // MSB first
            2'd1: scl_r <= 1'b1;
            2'd2: rsh_r <= {rsh_r[6:0], sda_sy_r[1]};
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) st_r <= M_ACK;
            end
          endcase
        end
        M_ACK: begin
          case (ph_r)
            2'd0: sda_r <= rx_r ? (left_r == 4'h1) : 1'b1;
            2'd1: scl_r <= 1'b1;
            2'd2: if (!rx_r && sda_sy_r[1]) nack_r <= 1'b1;
            default: begin
              scl_r <= 1'b0;
              byte_r <= byte_r + 3'h1;
              bit_r <= '0;
              if (rx_r) begin
                RDATA <= rsh_r; RVALID <= 1'b1; left_r <= left_r - 4'h1;
                st_r <= (left_r == 4'h1) ? M_STOP : M_BIT;
              end else if (nack_r) st_r <= M_STOP;
              else if (byte_r == 3'd0) begin sh_r <= ADDR; st_r <= M_BIT; end
              else if (byte_r == 3'd1 && rnw_r) begin
                sh_r <= {DPOT_ID_PREFIX, SEL, 1'b0, 1'b1}; st_r <= M_RSTART;
              end else if (byte_r == 3'd1) begin sh_r <= WDATA; st_r <= M_BIT; end
              else if (byte_r == 3'd2 && rnw_r) begin rx_r <= 1'b1; st_r <= M_BIT; end
              else st_r <= M_STOP;
            end
          endcase
        end
        M_STOP: begin
          case (ph_r)
            2'd0: sda_r <= 1'b0;
            2'd1: scl_r <= 1'b1;
            2'd2: sda_r <= 1'b1;
            default: st_r <= M_DONE;
          endcase
        end
        default: begin st_r <= M_IDLE; DONE <= 1'b1; NACK <= nack_r; end
      endcase
    end
  end
  always_comb begin
    BUS.scl_o        = 1'b0;
    BUS.scl_oe_n     = scl_r;
    BUS.sda_mst_o    = 1'b0;
    BUS.sda_mst_oe_n = sda_r;
  end
  assign BUSY = (st_r != M_IDLE);
endmodule : dpot_master

// file: pisa_properties.sv
`timescale 1ns/1ps
module pisa_properties
  import dpot_pkg::*;
(
  input wire logic CLOCK,        // System clock
  input wire logic RESETN,       // Sync reset, low active
  input wire logic scl,          // Clock wire
  input wire logic sda,          // Data wire
  input wire logic scl_o,        // Master clock level
  input wire logic scl_oe_n,     // Master clock enable
  input wire logic sda_mst_o,    // Master data level
  input wire logic sda_mst_oe_n, // Master data enable
  input wire logic sda_dev_o,    // Device data level
  input wire logic sda_dev_oe_n, // Device data enable
  input wire logic sel           // Address select strap
);
  // ==========================================================
  // Frame tracking
  logic       scl_d_r, sda_d_r, ack_r, rw_r;
  logic [3:0] cnt_r, byte_r;
  logic [4:0] pu_r;
  logic [7:0] sh_r;
  always_ff @(posedge CLOCK) begin
    scl_d_r <= RESETN ? scl : 1'b1;
    sda_d_r <= RESETN ? sda : 1'b1;
  end
  always_ff @(posedge CLOCK) begin
    if (!RESETN) pu_r <= 5'h00;
    else if (pu_r < 5'h10) pu_r <= pu_r + 5'h01;
  end
  // Byte index 4'hf means no frame open
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cnt_r  <= 4'h0;
      byte_r <= 4'hf;
      ack_r  <= 1'b0;
      rw_r   <= 1'b0;
      sh_r   <= 8'h00;
    end else if (scl && scl_d_r && sda_d_r && !sda) begin
      cnt_r  <= 4'h0;
      byte_r <= 4'h0;
      ack_r  <= 1'b0;
    end else if (scl && scl_d_r && !sda_d_r && sda) begin
      byte_r <= 4'hf;
      ack_r  <= 1'b0;
    end else if (scl && !scl_d_r) begin
      if (cnt_r == 4'h8) begin
        cnt_r <= 4'h0;
        if (byte_r == 4'h0) begin
          ack_r <= !sda;
          rw_r  <= sh_r[0];
        end
        if (byte_r < 4'he) byte_r <= byte_r + 4'h1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
        sh_r  <= {sh_r[6:0], sda};
      end
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_stop;
    (scl && !sda) ##1 (scl && sda);
  endsequence
  sequence s_ninth;
    scl && !scl_d_r && cnt_r == 4'h8;
  endsequence
  wire in_frame = byte_r != 4'h0 && byte_r != 4'hf;
  property p_rst_release;  $rose(RESETN) |-> sda_dev_oe_n; endproperty
  property p_pwrup_quiet;  pu_r < 5'h10 |-> sda_dev_oe_n; endproperty
  property p_dev_drain;    !sda_dev_oe_n |-> !sda_dev_o; endproperty
  property p_mst_drain;    (sda_mst_oe_n || !sda_mst_o) && (scl_oe_n || !scl_o); endproperty
  property p_dev_stable;   scl && scl_d_r |-> $stable(sda_dev_oe_n); endproperty
  property p_id_listen;    scl && !scl_d_r && cnt_r != 4'h8 && byte_r == 4'h0 |-> sda_dev_oe_n; endproperty
  property p_id_nack;
    s_ninth ##0 (byte_r == 4'h0 && (sh_r[7:3] != DPOT_ID_PREFIX || sh_r[DPOT_ID_SEL_BIT] != sel)) |-> sda_dev_oe_n;
  endproperty
  property p_quiet_nack;   scl && !scl_d_r && in_frame && !ack_r |-> sda_dev_oe_n; endproperty
  property p_write_ack;    s_ninth ##0 (in_frame && ack_r && !rw_r) |-> !sda_dev_oe_n; endproperty
  property p_read_release; s_ninth ##0 (in_frame && ack_r && rw_r) |-> sda_dev_oe_n; endproperty
  property p_stop_idle;    s_stop |=> sda_dev_oe_n [*8]; endproperty
  a_rst_release:  assert property (p_rst_release)  else $error("data driver held at reset");
  a_pwrup_quiet:  assert property (p_pwrup_quiet)  else $error("driven during power up");
  a_dev_drain:    assert property (p_dev_drain)    else $error("device drives data high");
  a_mst_drain:    assert property (p_mst_drain)    else $error("master drives a wire high");
  a_dev_stable:   assert property (p_dev_stable)   else $error("device data moved with clock high");
  a_id_listen:    assert property (p_id_listen)    else $error("device drives during id byte");
  a_id_nack:      assert property (p_id_nack)      else $error("foreign id acknowledged");
  a_quiet_nack:   assert property (p_quiet_nack)   else $error("device active after foreign id");
  a_write_ack:    assert property (p_write_ack)    else $error("write byte not acknowledged");
  a_read_release: assert property (p_read_release) else $error("device holds data in master ack");
  a_stop_idle:    assert property (p_stop_idle)    else $error("device active after stop");
endmodule : pisa_properties

// file: test_pot_i2c_slave_access.sv
`timescale 1ns/1ps
module test_pot_i2c_slave_access;
  import dpot_pkg::*;
  // ==========================================================
  // Signals and model state
  logic        clk = 1'b0;
  logic        resetn, req, rnw, sel, pin, busy, done, nack, rvalid;
  logic        div_mode, prec_off, shdn_n, nv_busy;
  logic [7:0]  addr, wdata, rdata;
  logic [3:0]  rcount;
  logic [6:0]  wiper;
  logic [31:0] seed;
  logic [7:0]  rq[$];
  int          failures = 0;
  int          n_tests = 0;
  int          m_wiper = 64, m_init = 64, m_vol = 0, m_shdn = 1, m_busy = 0, m_mode = 0, v;
  dpot_if i_dpot_if ();
  // Long nonvolatile cycle shortened, still spans two frames
  dpot_slave #(.NVW_CYC(10000)) i_dpot_slave (.CLOCK(clk), .RESETN(resetn), .BUS(i_dpot_if),
    .ADDR_SELECT_PIN(pin), .WIPER(wiper), .DIVIDER_MODE(div_mode), .PRECISION_OFF(prec_off),
    .SHUTDOWN_N(shdn_n), .NV_WRITE_BUSY(nv_busy));
  dpot_master i_dpot_master (.CLOCK(clk), .RESETN(resetn), .BUS(i_dpot_if), .REQ(req), .RNW(rnw),
    .SEL(sel), .ADDR(addr), .WDATA(wdata), .RCOUNT(rcount), .BUSY(busy), .DONE(done), .NACK(nack),
    .RDATA(rdata), .RVALID(rvalid));
  pisa_properties i_pisa_properties (.CLOCK(clk), .RESETN(resetn), .scl(i_dpot_if.scl),
    .sda(i_dpot_if.sda), .scl_o(i_dpot_if.scl_o), .scl_oe_n(i_dpot_if.scl_oe_n),
    .sda_mst_o(i_dpot_if.sda_mst_o), .sda_mst_oe_n(i_dpot_if.sda_mst_oe_n),
    .sda_dev_o(i_dpot_if.sda_dev_o), .sda_dev_oe_n(i_dpot_if.sda_dev_oe_n), .sel(pin));
  always #5 clk = ~clk;
  always @(negedge clk) if (rvalid === 1'b1) rq.push_back(rdata);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report;
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic r, input logic s, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] c);
    for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge clk);
    req = 1'b1;
    rnw = r;
    sel = s;
    addr = a;
    wdata = d;
    rcount = c;
    @(negedge clk);
    req = 1'b0;
    for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
    chk("done", {7'h0, done}, 8'h01);
  endtask : xfer
  task automatic wr(input int a, input int d);
    xfer(1'b0, pin, 8'(a), 8'(d), 4'h1);
    chk("write nack", {7'h0, nack}, 8'h00);
    // Busy drops writes to wiper and access control, mode stays writable
    if (a == 1) begin
      m_busy = 1;
      m_mode = d & 192;
    end
    else if (m_busy == 0 && a == 0) begin
      m_wiper = d & 127;
      if (m_vol == 0) begin
        m_init = d & 127;
        m_busy = 1;
      end
    end else if (m_busy == 0 && a == 2) begin
      m_vol = (d >> 7) & 1;
      m_shdn = (d >> 6) & 1;
    end
  endtask : wr
  task automatic rd(input int a, input logic [3:0] c);
    int e;
    e = (a == 0) ? (m_vol ? m_wiper : m_init) : (a == 1) ? m_mode :
        (a == 2) ? m_vol * 128 + m_shdn * 64 + m_busy * 32 : 0;
    rq.delete();
    xfer(1'b1, pin, 8'(a), 8'h00, c);
    chk("read nack", {7'h0, nack}, 8'h00);
    chk("read count", 8'(rq.size()), {4'h0, c});
    foreach (rq[k]) chk("read data", rq[k], 8'(e));
  endtask : rd
  task automatic settle;
    for (int i = 0; i < 15000 && nv_busy !== 1'b0; i++) @(negedge clk);
    m_busy = 0;
    chk("busy end", {7'h0, nv_busy}, 8'h00);
  endtask : settle
  // ==========================================================
  // Sequence
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    seed = lfsr(32'hb9df7672);
    pin = seed[0];
    {resetn, req, rnw, sel, addr, wdata, rcount} = {3'h0, 1'b0, 16'h0000, 4'h1};
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (30) @(negedge clk);
    chk("wiper", {1'b0, wiper}, 8'h40);
    chk("mode", {6'h0, div_mode, prec_off}, 8'h00);
    chk("shutdown", {6'h0, shdn_n, nv_busy}, 8'h02);
    rd(2, 4'h1);
    wr(1, 8'hc0);
    chk("mode", {6'h0, div_mode, prec_off}, 8'h03);
    chk("busy", {7'h0, nv_busy}, 8'h01);
    wr(2, 8'h80);
    rd(2, 4'h1);
    settle();
    seed = lfsr(seed);
    v = seed[6:0];
    wr(0, v);
    chk("wiper", {1'b0, wiper}, 8'(m_wiper));
    chk("busy", {7'h0, nv_busy}, 8'h01);
    settle();
    wr(2, 8'h80);
    chk("shutdown", {7'h0, shdn_n}, 8'h00);
    wr(0, 8'h7f);
    chk("wiper", {1'b0, wiper}, 8'h7f);
    chk("busy", {7'h0, nv_busy}, 8'h00);
    rd(0, 4'h3);
    wr(2, 8'h40);
    rd(2, 4'h1);
    rd(0, 4'h2);
    xfer(1'b0, !pin, 8'h00, 8'h11, 4'h1);
    chk("foreign nack", {7'h0, nack}, 8'h01);
    chk("wiper", {1'b0, wiper}, 8'h7f);
    rd(1, 4'h1);
    rd(3, 4'h1);
    final_report();
  end
endmodule : test_pot_i2c_slave_access
